// [rtl/mac_ctrl_stats_pkg.sv]
// Contract
// - Count every control frame transmit request
// - Count valid received control-type frames
// - Count received control frames with unsupported opcode
// - Read-write list: PAUSE and multipoint support
// - Store PAUSE delay allowance in bits
// - Count PAUSE transmit requests
// - Count valid received PAUSE frames
// - Disabled admin state hides multipoint functions; OAM link status still follows registration state
// - Admin state changed only by action
// - Read-only role: OLT or ONU
// - Read-only logical link number
// - Capture source of multicast multipoint frames
// - Report unregistered, registering, registered state
// - Signal OAM link OK or FAIL
// - Count multipoint transmit requests
// - Count valid received multipoint frames
// - Count GATE transmit requests
// - No clearing of event counters
package mac_ctrl_stats_pkg;
    localparam logic [7:0] OFS_CTRL_TX = 8'h00;
    localparam logic [7:0] OFS_CTRL_RX = 8'h04;
    localparam logic [7:0] OFS_UNK_RX = 8'h08;
    localparam logic [7:0] OFS_PAUSE_TX = 8'h0C;
    localparam logic [7:0] OFS_PAUSE_RX = 8'h10;
    localparam logic [7:0] OFS_MP_TX = 8'h14;
    localparam logic [7:0] OFS_MP_RX = 8'h18;
    localparam logic [7:0] OFS_GATE_TX = 8'h1C;
    localparam logic [7:0] OFS_FUNC_LIST = 8'h20;
    localparam logic [7:0] OFS_DELAY = 8'h24;
    localparam logic [7:0] OFS_MP_STATUS = 8'h28;
    localparam logic [7:0] OFS_ADMIN_ACT = 8'h2C;
    localparam logic [7:0] OFS_LINK_NUM = 8'h30;
    localparam logic [7:0] OFS_REMOTE_LO = 8'h34;
    localparam logic [7:0] OFS_REMOTE_HI = 8'h38;
    // Function list bits
    localparam int FUNC_PAUSE_BIT = 0;
    localparam int FUNC_MP_BIT = 1;
    localparam logic [1:0] FUNC_LIST_RST = 2'h3;
    // Status word fields
    localparam int ST_ADMIN_BIT = 0;
    localparam int ST_ROLE_BIT = 1;
    localparam int ST_REG_LSB = 2;
    localparam logic [31:0] DELAY_RST = 32'h0000_0000;
    localparam logic ADMIN_RST = 1'b0;
    // Frame field values
    localparam logic [15:0] CTRL_TYPE = 16'h8808;
    localparam logic [47:0] CTRL_MCAST = 48'h0180_C200_0001;
    localparam logic [15:0] OP_PAUSE = 16'h0001;
    localparam logic [15:0] OP_GATE = 16'h0002;
    localparam logic [15:0] OP_MP_LAST = 16'h0006;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        REG_UNREGISTERED = 2'b00,
        REG_REGISTERING = 2'b01,
        REG_REGISTERED = 2'b10
    } reg_state_t;
    typedef enum logic {
        ROLE_OLT = 1'b0,
        ROLE_ONU = 1'b1
    } mp_role_t;
endpackage : mac_ctrl_stats_pkg

// [rtl/mac_control_mgmt_stats.sv]
module mac_control_mgmt_stats
    import mac_ctrl_stats_pkg::*;
#(
    parameter int CNT_W = 32,
    parameter int LINK_W = 16
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Transmit requests from the control sublayer
    input wire logic tx_req_i,
    input wire logic [15:0] tx_opcode_i,
    // Received frames returned by the MAC
    input wire logic rx_frame_valid_i,
    input wire logic [47:0] rx_dest_addr_i,
    input wire logic [47:0] rx_src_addr_i,
    input wire logic [15:0] rx_len_type_i,
    input wire logic [15:0] rx_opcode_i,
    // Multipoint engine state
    input wire logic multipoint_role_i,
    input wire logic [LINK_W-1:0] logical_link_number_i,
    input wire logic [1:0] registration_state_i,
    // Settings to the control functions
    output logic multipoint_admin_state_o,
    output logic [31:0] pause_delay_allowance_bits_o,
    output logic [1:0] ctrl_function_list_o,
    // OAM link status
    output logic oam_link_status_request_o,
    output logic oam_link_status_ok_o,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);

    function automatic logic [CNT_W-1:0] bump(
        input logic [CNT_W-1:0] cnt,
        input logic hit
    );
        // Plain binary wrap past the maximum
        bump = hit ? cnt + CNT_W'(1) : cnt;
    endfunction : bump

    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        merge = res;
    endfunction : merge

    function automatic logic is_mp_op(input logic [15:0] op);
        is_mp_op = (op >= OP_GATE) && (op <= OP_MP_LAST);
    endfunction : is_mp_op

    // Counters, captured remote source address and previous registration state
    logic [CNT_W-1:0] ctrl_frames_tx_count_r;
    logic [CNT_W-1:0] ctrl_frames_rx_count_r;
    logic [CNT_W-1:0] unknown_opcode_rx_count_r;
    logic [CNT_W-1:0] pause_frames_tx_count_r;
    logic [CNT_W-1:0] pause_frames_rx_count_r;
    logic [CNT_W-1:0] multipoint_frames_tx_count_r;
    logic [CNT_W-1:0] multipoint_frames_rx_count_r;
    logic [CNT_W-1:0] gate_frames_tx_count_r;
    logic [47:0] last_remote_source_addr_r;
    logic [1:0] reg_state_prev_r;

    // Bus state
    logic aw_have_r;
    logic w_have_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_go;
    logic wr_mapped;
    logic [31:0] rd_word;
    logic rd_mapped;

    // Frame event decode
    logic mp_on;
    logic rx_ctrl;
    logic rx_pause;
    logic rx_mp;
    logic rx_supported;
    logic tx_pause;
    logic tx_mp;
    logic tx_gate;

    assign mp_on = multipoint_admin_state_o;
    assign rx_ctrl = rx_frame_valid_i && (rx_len_type_i == CTRL_TYPE);
    assign rx_pause = rx_ctrl && (rx_opcode_i == OP_PAUSE);
    // With multipoint disabled its opcodes are treated as absent
    assign rx_mp = rx_ctrl && mp_on && is_mp_op(rx_opcode_i);
    assign rx_supported = (rx_pause && ctrl_function_list_o[FUNC_PAUSE_BIT])
        || (rx_mp && ctrl_function_list_o[FUNC_MP_BIT]);
    assign tx_pause = tx_req_i && (tx_opcode_i == OP_PAUSE);
    assign tx_mp = tx_req_i && mp_on && is_mp_op(tx_opcode_i);
    assign tx_gate = tx_req_i && mp_on && (tx_opcode_i == OP_GATE);

    // Counters are never reset by software, only advanced; all update in one edge
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_frames_tx_count_r <= '0;
            ctrl_frames_rx_count_r <= '0;
            unknown_opcode_rx_count_r <= '0;
            pause_frames_tx_count_r <= '0;
            pause_frames_rx_count_r <= '0;
            multipoint_frames_tx_count_r <= '0;
            multipoint_frames_rx_count_r <= '0;
            gate_frames_tx_count_r <= '0;
        end else begin
            ctrl_frames_tx_count_r <= bump(ctrl_frames_tx_count_r, tx_req_i);
            ctrl_frames_rx_count_r <= bump(ctrl_frames_rx_count_r, rx_ctrl);
            unknown_opcode_rx_count_r <= bump(unknown_opcode_rx_count_r,
                rx_ctrl && !rx_supported);
            pause_frames_tx_count_r <= bump(pause_frames_tx_count_r, tx_pause);
            pause_frames_rx_count_r <= bump(pause_frames_rx_count_r, rx_pause);
            multipoint_frames_tx_count_r <= bump(multipoint_frames_tx_count_r, tx_mp);
            multipoint_frames_rx_count_r <= bump(multipoint_frames_rx_count_r, rx_mp);
            gate_frames_tx_count_r <= bump(gate_frames_tx_count_r, tx_gate);
        end
    end

    // Source of the latest multicast multipoint frame
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            last_remote_source_addr_r <= '0;
        end else if (rx_mp && (rx_dest_addr_i == CTRL_MCAST)) begin
            last_remote_source_addr_r <= rx_src_addr_i;
        end
    end

    // OAM link status follows registration transitions
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_state_prev_r <= REG_UNREGISTERED;
            oam_link_status_request_o <= 1'b0;
            oam_link_status_ok_o <= 1'b0;
        end else begin
            reg_state_prev_r <= registration_state_i;
            oam_link_status_request_o <= 1'b0;
            if (reg_state_prev_r == REG_REGISTERING && registration_state_i == REG_REGISTERED) begin
                oam_link_status_request_o <= 1'b1;
                oam_link_status_ok_o <= 1'b1;
            end else if (reg_state_prev_r == REG_REGISTERED
                && registration_state_i == REG_UNREGISTERED) begin
                oam_link_status_request_o <= 1'b1;
                oam_link_status_ok_o <= 1'b0;
            end
        end
    end

    // Write channel: address and data taken in either order
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_have_r <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            w_have_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_have_r <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

    always_comb begin
        unique case (aw_addr_r)
            OFS_CTRL_TX, OFS_CTRL_RX, OFS_UNK_RX, OFS_PAUSE_TX,
            OFS_PAUSE_RX, OFS_MP_TX, OFS_MP_RX, OFS_GATE_TX,
            OFS_FUNC_LIST, OFS_DELAY, OFS_MP_STATUS, OFS_ADMIN_ACT,
            OFS_LINK_NUM, OFS_REMOTE_LO, OFS_REMOTE_HI: wr_mapped = 1'b1;
            default: wr_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Writable settings
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_function_list_o <= FUNC_LIST_RST;
        end else if (wr_go && aw_addr_r == OFS_FUNC_LIST && w_strb_r[0]) begin
            ctrl_function_list_o <= w_data_r[1:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pause_delay_allowance_bits_o <= DELAY_RST;
        end else if (wr_go && aw_addr_r == OFS_DELAY) begin
            pause_delay_allowance_bits_o <= merge(pause_delay_allowance_bits_o,
                w_data_r, w_strb_r);
        end
    end

    // Admin state moves only through the action word; status word is read-only
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            multipoint_admin_state_o <= ADMIN_RST;
        end else if (wr_go && aw_addr_r == OFS_ADMIN_ACT && w_strb_r[0]) begin
            multipoint_admin_state_o <= w_data_r[0];
        end
    end

    // Read decode
    always_comb begin
        rd_word = '0;
        rd_mapped = 1'b1;
        unique case (s_axi_araddr)
            OFS_CTRL_TX: rd_word = 32'(ctrl_frames_tx_count_r);
            OFS_CTRL_RX: rd_word = 32'(ctrl_frames_rx_count_r);
            OFS_UNK_RX: rd_word = 32'(unknown_opcode_rx_count_r);
            OFS_PAUSE_TX: rd_word = 32'(pause_frames_tx_count_r);
            OFS_PAUSE_RX: rd_word = 32'(pause_frames_rx_count_r);
            OFS_MP_TX: rd_word = 32'(multipoint_frames_tx_count_r);
            OFS_MP_RX: rd_word = 32'(multipoint_frames_rx_count_r);
            OFS_GATE_TX: rd_word = 32'(gate_frames_tx_count_r);
            OFS_FUNC_LIST: rd_word[1:0] = ctrl_function_list_o;
            OFS_DELAY: rd_word = pause_delay_allowance_bits_o;
            OFS_MP_STATUS: begin
                rd_word[ST_ADMIN_BIT] = multipoint_admin_state_o;
                rd_word[ST_ROLE_BIT] = multipoint_role_i;
                rd_word[ST_REG_LSB +: 2] = registration_state_i;
            end
            OFS_ADMIN_ACT: rd_word = '0;
            OFS_LINK_NUM: rd_word[LINK_W-1:0] = logical_link_number_i;
            OFS_REMOTE_LO: rd_word = last_remote_source_addr_r[31:0];
            OFS_REMOTE_HI: rd_word[15:0] = last_remote_source_addr_r[47:32];
            default: rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : mac_control_mgmt_stats

// [sim/mac_ctrl_stats_sva.sv]
module mac_ctrl_stats_sva
    import mac_ctrl_stats_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Multipoint state and OAM
    input wire logic [1:0] registration_state_i,
    input wire logic multipoint_admin_state_o,
    input wire logic oam_link_status_request_o,
    input wire logic oam_link_status_ok_o,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write not answered");
    a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("second write accepted");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed");
    a_oam_link_ok: assert property (registration_state_i == REG_REGISTERED
        && $past(registration_state_i) == REG_REGISTERING
        |=> oam_link_status_request_o && oam_link_status_ok_o) else $error("no OK status");
    a_oam_link_fail: assert property (registration_state_i == REG_UNREGISTERED
        && $past(registration_state_i) == REG_REGISTERED
        |=> oam_link_status_request_o && !oam_link_status_ok_o) else $error("no FAIL status");
    a_oam_quiet: assert property ($stable(registration_state_i) |=> !oam_link_status_request_o)
        else $error("stray status request");
    a_admin_by_write: assert property (!$stable(multipoint_admin_state_o) |-> $rose(s_axi_bvalid))
        else $error("admin state moved without write");
endmodule : mac_ctrl_stats_sva

bind mac_control_mgmt_stats mac_ctrl_stats_sva mac_ctrl_stats_sva_i (.*);

// [sim/mac_frame_source.sv]
module mac_frame_source
    import mac_ctrl_stats_pkg::*;
(
    // Clock
    input wire logic core_clk_i,
    // Transmit requests
    output logic tx_req_o = 1'b0,
    output logic [15:0] tx_opcode_o = 16'h0000,
    // Received frames
    output logic rx_frame_valid_o = 1'b0,
    output logic [47:0] rx_dest_addr_o = 48'h0000_0000_0000,
    output logic [47:0] rx_src_addr_o = 48'h0000_0000_0000,
    output logic [15:0] rx_len_type_o = 16'h0000,
    output logic [15:0] rx_opcode_o = 16'h0000,
    // Multipoint engine state
    output logic multipoint_role_o = ROLE_ONU,
    output logic [15:0] logical_link_number_o = 16'h005A,
    output logic [1:0] registration_state_o = REG_UNREGISTERED
);
    timeunit 1ns;
    timeprecision 1ns;
    // One pulse per event; fields turn over once the pulse is gone
    task automatic send_tx(input logic [15:0] op);
        @(posedge core_clk_i);
        tx_req_o <= 1'b1;
        tx_opcode_o <= op;
        @(posedge core_clk_i);
        tx_req_o <= 1'b0;
        tx_opcode_o <= ~op;
    endtask : send_tx
    task automatic send_rx(input logic [47:0] da, input logic [47:0] sa, input logic [15:0] ty, input logic [15:0] op);
        @(posedge core_clk_i);
        rx_frame_valid_o <= 1'b1;
        {rx_dest_addr_o, rx_src_addr_o, rx_len_type_o, rx_opcode_o} <= {da, sa, ty, op};
        @(posedge core_clk_i);
        rx_frame_valid_o <= 1'b0;
        {rx_dest_addr_o, rx_src_addr_o, rx_len_type_o, rx_opcode_o} <= ~{da, sa, ty, op};
    endtask : send_rx
    task automatic set_role(input logic r);
        @(posedge core_clk_i);
        multipoint_role_o <= r;
    endtask : set_role
    task automatic move_reg(input logic [1:0] st);
        @(posedge core_clk_i);
        registration_state_o <= st;
        repeat (3) @(posedge core_clk_i);
    endtask : move_reg
endmodule : mac_frame_source

// [sim/mac_control_mgmt_stats_bench.sv]
module mac_control_mgmt_stats_bench
    import mac_ctrl_stats_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic tx_req_i, rx_frame_valid_i, multipoint_role_i;
    logic [15:0] tx_opcode_i, rx_len_type_i, rx_opcode_i, logical_link_number_i;
    logic [47:0] rx_dest_addr_i, rx_src_addr_i;
    logic [1:0] registration_state_i, s_axi_bresp, s_axi_rresp, ctrl_function_list_o;
    logic multipoint_admin_state_o, oam_link_status_request_o, oam_link_status_ok_o;
    logic [31:0] pause_delay_allowance_bits_o, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [31:0] exp_cnt [8];
    int n_mismatch = 0, n_checks = 0, cycles = 0;
    int n_ok = 0, n_fail = 0;
    always #20 core_clk_i = ~core_clk_i;
    mac_control_mgmt_stats mac_control_mgmt_stats_i (.*);
    mac_frame_source src (.core_clk_i(core_clk_i), .tx_req_o(tx_req_i), .tx_opcode_o(tx_opcode_i),
        .rx_frame_valid_o(rx_frame_valid_i), .rx_dest_addr_o(rx_dest_addr_i), .rx_src_addr_o(rx_src_addr_i),
        .rx_len_type_o(rx_len_type_i), .rx_opcode_o(rx_opcode_i), .multipoint_role_o(multipoint_role_i),
        .logical_link_number_o(logical_link_number_i), .registration_state_o(registration_state_i));
    task automatic check(input logic [33:0] seen, input logic [33:0] want);
        n_checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("mismatch at %0t ns: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge core_clk_i);
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        // Each channel is released at the edge that takes it
        while (!(aw_done && w_done)) begin
            @(posedge core_clk_i);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk_i); while (!s_axi_bvalid);
        s_axi_bready <= 1'b1;
        do @(posedge core_clk_i); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check({s_axi_bresp, 32'h0000_0000}, {er, 32'h0000_0000});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge core_clk_i);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        do @(posedge core_clk_i); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk_i); while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        do @(posedge core_clk_i); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check({s_axi_rresp, s_axi_rdata}, {er, e});
    endtask : rd
    // Mask bits follow the counter order in the map, ctrl tx first
    task automatic frames(input logic [7:0] m);
        for (int i = 0; i < 8; i++) if (m[i]) exp_cnt[i] += 32'h0000_0001;
    endtask : frames
    task automatic all_counts();
        for (int i = 0; i < 8; i++) rd(8'(4 * i), exp_cnt[i], RESP_OKAY);
    endtask : all_counts
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    // Count OAM status pulses by the level that they carry
    always @(posedge core_clk_i) begin
        if (oam_link_status_request_o === 1'b1) begin
            if (oam_link_status_ok_o === 1'b1) begin
                n_ok++;
            end else begin
                n_fail++;
            end
        end
    end
    initial begin
        foreach (exp_cnt[i]) exp_cnt[i] = 32'h0000_0000;
        repeat (5) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        rd(OFS_FUNC_LIST, 32'h0000_0003, RESP_OKAY);
        rd(OFS_DELAY, 32'h0000_0000, RESP_OKAY);
        wr(OFS_DELAY, 32'hA5C3_0F1E, RESP_OKAY);
        rd(OFS_DELAY, 32'hA5C3_0F1E, RESP_OKAY);
        check(34'(pause_delay_allowance_bits_o), 34'h0_A5C3_0F1E);
        s_axi_wstrb <= 4'h5;
        wr(OFS_DELAY, 32'h1122_3344, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(OFS_DELAY, 32'hA522_0F44, RESP_OKAY);
        check(34'(pause_delay_allowance_bits_o), 34'h0_A522_0F44);
        wr(OFS_FUNC_LIST, 32'h0000_0002, RESP_OKAY);
        rd(OFS_FUNC_LIST, 32'h0000_0002, RESP_OKAY);
        check(34'(ctrl_function_list_o), 34'h0_0000_0002);
        wr(OFS_MP_STATUS, 32'h0000_000F, RESP_OKAY);
        rd(OFS_MP_STATUS, 32'h0000_0002, RESP_OKAY);
        check(34'(multipoint_admin_state_o), 34'h0_0000_0000);
        rd(OFS_LINK_NUM, 32'h0000_005A, RESP_OKAY);
        rd(8'h3C, 32'h0000_0000, RESP_SLVERR);
        src.send_rx(CTRL_MCAST, 48'h0A1B_2C3D_4E5F, CTRL_TYPE, OP_PAUSE);
        frames(8'h16);
        wr(OFS_FUNC_LIST, 32'h0000_0003, RESP_OKAY);
        src.send_rx(CTRL_MCAST, 48'h0A1B_2C3D_4E5F, CTRL_TYPE, OP_PAUSE);
        frames(8'h12);
        src.send_rx(CTRL_MCAST, 48'h0A1B_2C3D_4E5F, 16'h0800, OP_PAUSE);
        src.send_rx(CTRL_MCAST, 48'h0A1B_2C3D_4E5F, CTRL_TYPE, 16'h0004);
        frames(8'h06);
        src.send_tx(OP_PAUSE);
        frames(8'h09);
        src.send_tx(OP_GATE);
        frames(8'h01);
        all_counts();
        rd(OFS_REMOTE_LO, 32'h0000_0000, RESP_OKAY);
        wr(OFS_ADMIN_ACT, 32'h0000_0001, RESP_OKAY);
        rd(OFS_MP_STATUS, 32'h0000_0003, RESP_OKAY);
        check(34'(multipoint_admin_state_o), 34'h0_0000_0001);
        src.send_rx(CTRL_MCAST, 48'h0A1B_2C3D_4E5F, CTRL_TYPE, 16'h0003);
        frames(8'h42);
        src.send_rx(48'h0200_0000_0001, 48'h0600_0000_0007, CTRL_TYPE, 16'h0005);
        frames(8'h42);
        src.send_tx(OP_GATE);
        frames(8'hA1);
        src.send_tx(OP_MP_LAST);
        frames(8'h21);
        src.send_rx(CTRL_MCAST, 48'h0A1B_2C3D_4E5F, CTRL_TYPE, 16'h0007);
        frames(8'h06);
        wr(OFS_CTRL_TX, 32'h0000_0000, RESP_OKAY);
        all_counts();
        rd(OFS_REMOTE_LO, 32'h2C3D_4E5F, RESP_OKAY);
        rd(OFS_REMOTE_HI, 32'h0000_0A1B, RESP_OKAY);
        src.move_reg(REG_REGISTERING);
        rd(OFS_MP_STATUS, 32'h0000_0007, RESP_OKAY);
        check(34'(n_ok), 34'h0_0000_0000);
        check(34'(n_fail), 34'h0_0000_0000);
        src.move_reg(REG_REGISTERED);
        rd(OFS_MP_STATUS, 32'h0000_000B, RESP_OKAY);
        check(34'(n_ok), 34'h0_0000_0001);
        check(34'(n_fail), 34'h0_0000_0000);
        check(34'(oam_link_status_ok_o), 34'h0_0000_0001);
        src.move_reg(REG_UNREGISTERED);
        rd(OFS_MP_STATUS, 32'h0000_0003, RESP_OKAY);
        check(34'(n_ok), 34'h0_0000_0001);
        check(34'(n_fail), 34'h0_0000_0001);
        check(34'(oam_link_status_ok_o), 34'h0_0000_0000);
        src.set_role(ROLE_OLT);
        rd(OFS_MP_STATUS, 32'h0000_0001, RESP_OKAY);
        close_out();
    end
endmodule : mac_control_mgmt_stats_bench
